// ===== rtl/cms_pkg.sv
package cms_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned LOAD_LIMIT_MS = 100;
  localparam longint unsigned LOAD_LIMIT_CYC_L =
    64'(LOAD_LIMIT_MS) * 64'(CLK_HZ) / 64'd1000;
  localparam int unsigned LOAD_LIMIT_CYC = 32'(LOAD_LIMIT_CYC_L);
  localparam int unsigned PAR_TOP_HZ = 100_000_000;
  localparam int unsigned INIT_CYCLES = 8;
  localparam int unsigned WRITE_DIV = 2;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned PAR_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CFG_BYTES = 16;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned PLL_FIELD_W = 6;
  localparam logic [7:0] CHECKSUM_RST = 8'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SCH_MEMORY,
    SCH_PASSIVE_SERIAL,
    SCH_PASSIVE_PARALLEL_ASYNC,
    SCH_FAST_PASSIVE_PARALLEL,
    SCH_SCAN
  } cms_scheme_t;

  typedef struct packed {
    logic mem_valid;
    logic [PAR_WIDTH-1:0] mem_byte;
    logic ps_valid;
    logic ps_bit;
    logic ppa_valid;
    logic [PAR_WIDTH-1:0] ppa_byte;
    logic fpp_valid;
    logic [PAR_WIDTH-1:0] fpp_byte;
    logic scan_valid;
    logic scan_bit;
  } cms_src_t;

  typedef struct packed {
    logic shift_en;
    logic sel_io;
    logic core_bit;
    logic io_bit;
    logic update;
  } cms_pll_in_t;

  typedef struct packed {
    logic [PLL_FIELD_W-1:0] mult;
    logic [PLL_FIELD_W-1:0] div;
    logic [PLL_FIELD_W-1:0] delay;
  } cms_pll_set_t;

endpackage

// ===== rtl/cms_top.sv
// Behaviour
// - Volatile storage: every power-up starts unconfigured and must load data.
// - User I/O stays high-impedance through power-up, waiting and loading.
// - After load, initialization resets registers, enables I/O, then runs.
// - Load plus initialization is command mode; user mode only after both.
// - Reconfig request pin forces command mode, reload, reinit, user mode.
// - Enable input and enable output allow cascading devices in any scheme.
// - Exactly one selected scheme feeds configuration data.
// - Load must finish within 100 ms; overrun flags an error.
// - Host may deliver data serially or parallel, sync or async.
// - PLL counter settings shift in serially from core or I/O pins.
// - PLL reload keeps user mode and all other logic running.
// - Scan instruction triggers reconfiguration like a request pin pulse.

// ------------------------------------------------------------------
// Byte FIFO in the configuration data path
// ------------------------------------------------------------------
module cms_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic flush, // Empty and refuse input
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available, registered
  input wire logic [W-1:0] in_data, // Write data
  output logic out_valid, // Data available
  input wire logic out_ready, // Read request
  output logic [W-1:0] out_data // Head of queue
);
  localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
  localparam int unsigned CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic ready;
  } cms_fifo_state_t;

  cms_fifo_state_t r_reg;
  cms_fifo_state_t r_next;
  logic push;
  logic pop;

  assign out_valid = (r_reg.count != '0);
  assign out_data = r_reg.mem[r_reg.rd_ptr];
  assign in_ready = r_reg.ready;
  assign push = in_valid & r_reg.ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wr_ptr] = in_data;
      r_next.wr_ptr = (r_reg.wr_ptr == AW'(D - 1)) ? '0 : r_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      r_next.rd_ptr = (r_reg.rd_ptr == AW'(D - 1)) ? '0 : r_reg.rd_ptr + 1'b1;
    end
    r_next.count = r_reg.count + CW'(push) - CW'(pop);
    if (flush) begin
      r_next.wr_ptr = '0;
      r_next.rd_ptr = '0;
      r_next.count = '0;
    end
    // Registered ready keeps the source path free of comb loops
    r_next.ready = ~flush & (r_next.count != CW'(D));
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end
endmodule // cms_fifo

// ------------------------------------------------------------------
// Configuration mode sequencer
// ------------------------------------------------------------------
module cms_top #(
  parameter int unsigned LOAD_LIMIT = cms_pkg::LOAD_LIMIT_CYC,
  parameter int unsigned CFG_LEN = cms_pkg::CFG_BYTES,
  parameter int unsigned INIT_LEN = cms_pkg::INIT_CYCLES,
  parameter int unsigned FIFO_D = cms_pkg::FIFO_DEPTH
) (
  input wire logic clk, // 40 MHz system clock
  input wire logic rstn, // Power-up reset, active low
  input wire logic reconfig_request_n, // Reconfiguration request pin
  input wire logic scan_reconfig_pulse_instr, // Scan reconfig pulse
  input wire logic cfg_enable_in_n, // Cascade enable in
  input wire cms_pkg::cms_scheme_t scheme_sel, // Loading scheme strap
  input wire cms_pkg::cms_src_t src, // Data from all sources
  input wire cms_pkg::cms_pll_in_t pll_in, // PLL serial chain input
  output logic cfg_ready, // Data accepted when high
  output logic cfg_enable_out_n, // Cascade enable out
  output logic load_done, // Load complete
  output logic init_reset, // Register reset during init
  output logic user_mode, // Device in user mode
  output logic user_io_oe, // User I/O may drive
  output logic cfg_error, // Load overran time limit
  output logic [7:0] cfg_checksum, // XOR of loaded bytes
  output cms_pkg::cms_pll_set_t pll_settings // Active PLL counters
);
  import cms_pkg::*;

  localparam int unsigned PLL_W = $bits(cms_pll_set_t);

  typedef enum logic [2:0] {
    ST_CLEAR,
    ST_WAIT,
    ST_LOAD,
    ST_INIT,
    ST_USER,
    ST_ERROR
  } cms_st_t;

  typedef struct packed {
    cms_st_t state;
    cms_scheme_t scheme;
    logic [PAR_WIDTH-1:0] shreg;
    logic [2:0] bitcnt;
    logic [CNT_W-1:0] byte_cnt;
    logic [CNT_W-1:0] init_cnt;
    logic [31:0] timer;
    logic [1:0] div_cnt;
    logic [PLL_W-1:0] pll_chain;
    cms_pll_set_t pll_set;
    logic [7:0] checksum;
    logic ready_gate;
    logic en_out_n;
    logic done;
    logic init_rst;
    logic user;
    logic io_oe;
    logic err;
  } cms_top_state_t;

  localparam cms_top_state_t RST_STATE = '{
    state: ST_CLEAR, scheme: SCH_MEMORY, shreg: '0, bitcnt: '0,
    byte_cnt: '0, init_cnt: '0, timer: '0, div_cnt: '0,
    pll_chain: '0, pll_set: '0, checksum: CHECKSUM_RST,
    ready_gate: 1'b0, en_out_n: 1'b1, done: 1'b0, init_rst: 1'b0,
    user: 1'b0, io_oe: 1'b0, err: 1'b0};

  cms_top_state_t r_reg;
  cms_top_state_t r_next;

  logic fifo_ready;
  logic fifo_valid;
  logic [PAR_WIDTH-1:0] fifo_data;
  logic fifo_pop;
  logic flush;
  logic byte_valid;
  logic [PAR_WIDTH-1:0] byte_data;
  logic bit_valid;
  logic bit_val;
  logic loading;
  logic req;

  assign loading = (r_reg.state == ST_LOAD);
  assign flush = (r_next.state != ST_LOAD); // Ready falls as load ends
  assign fifo_pop = loading & (r_reg.div_cnt == '0);
  assign req = ~reconfig_request_n | scan_reconfig_pulse_instr;

  // ----------------------------------------------------------------
  // Source selection and serial assembly
  // ----------------------------------------------------------------
  // Only the scheme latched at load start is heard; others are ignored
  always_comb begin
    byte_valid = 1'b0;
    byte_data = '0;
    bit_valid = 1'b0;
    bit_val = 1'b0;
    unique case (r_reg.scheme)
      SCH_MEMORY: begin
        byte_valid = src.mem_valid;
        byte_data = src.mem_byte;
      end
      SCH_PASSIVE_SERIAL: begin
        bit_valid = src.ps_valid;
        bit_val = src.ps_bit;
      end
      SCH_PASSIVE_PARALLEL_ASYNC: begin
        byte_valid = src.ppa_valid;
        byte_data = src.ppa_byte;
      end
      SCH_FAST_PASSIVE_PARALLEL: begin
        byte_valid = src.fpp_valid;
        byte_data = src.fpp_byte;
      end
      SCH_SCAN: begin
        bit_valid = src.scan_valid;
        bit_val = src.scan_bit;
      end
      default: begin
        byte_valid = 1'b0;
      end
    endcase
    bit_valid = bit_valid & loading & fifo_ready;
    byte_valid = byte_valid & loading & fifo_ready;
    // Serial data arrives LSB first; the eighth bit completes a byte
    if (bit_valid && r_reg.bitcnt == 3'd7) begin
      byte_valid = 1'b1;
      byte_data = {bit_val, r_reg.shreg[PAR_WIDTH-1:1]};
    end
  end

  cms_fifo #(
    .W(PAR_WIDTH),
    .D(FIFO_D)
  ) u_fifo (
    .clk(clk),
    .rstn(rstn),
    .flush(flush),
    .in_valid(byte_valid),
    .in_ready(fifo_ready),
    .in_data(byte_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    if (bit_valid) begin
      r_next.shreg = {bit_val, r_reg.shreg[PAR_WIDTH-1:1]};
      r_next.bitcnt = r_reg.bitcnt + 3'd1;
    end
    if (loading) begin
      r_next.div_cnt = (r_reg.div_cnt == '0) ? 2'(WRITE_DIV - 1) :
                       r_reg.div_cnt - 2'd1;
    end
    unique case (r_reg.state)
      ST_CLEAR: begin
        if (!req) begin
          r_next.state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!cfg_enable_in_n) begin
          r_next.state = ST_LOAD;
          r_next.scheme = scheme_sel;
          r_next.timer = '0;
          r_next.byte_cnt = '0;
          r_next.bitcnt = '0;
          r_next.div_cnt = '0;
          r_next.checksum = CHECKSUM_RST;
        end
      end
      ST_LOAD: begin
        r_next.timer = r_reg.timer + 32'd1;
        if (fifo_pop && fifo_valid) begin
          r_next.checksum = r_reg.checksum ^ fifo_data;
          r_next.byte_cnt = r_reg.byte_cnt + 1'b1;
          if (r_reg.byte_cnt == CNT_W'(CFG_LEN - 1)) begin
            r_next.state = ST_INIT;
            r_next.done = 1'b1;
            r_next.en_out_n = 1'b0;
            r_next.init_cnt = '0;
            r_next.init_rst = 1'b1;
          end
        end
        if (r_next.state == ST_LOAD && r_reg.timer == LOAD_LIMIT - 1) begin
          r_next.state = ST_ERROR;
          r_next.err = 1'b1;
        end
      end
      ST_INIT: begin
        r_next.init_cnt = r_reg.init_cnt + 1'b1;
        if (r_reg.init_cnt == CNT_W'(INIT_LEN - 1)) begin
          r_next.state = ST_USER;
          r_next.init_rst = 1'b0;
          r_next.user = 1'b1;
          r_next.io_oe = 1'b1;
        end
      end
      ST_USER: begin
        // PLL reload never leaves user mode or touches other state
        if (pll_in.shift_en) begin
          r_next.pll_chain = {r_reg.pll_chain[PLL_W-2:0],
                              pll_in.sel_io ? pll_in.io_bit :
                                              pll_in.core_bit};
        end
        if (pll_in.update) begin
          r_next.pll_set = r_reg.pll_chain;
        end
      end
      ST_ERROR: begin
        r_next.state = ST_ERROR;
      end
      default: begin
        r_next.state = ST_CLEAR;
      end
    endcase
    // Request overrides every state; I/O released and cascade withdrawn
    if (req) begin
      r_next.state = ST_CLEAR;
      r_next.done = 1'b0;
      r_next.en_out_n = 1'b1;
      r_next.init_rst = 1'b0;
      r_next.user = 1'b0;
      r_next.io_oe = 1'b0;
      r_next.err = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= RST_STATE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign cfg_ready = fifo_ready;
  assign cfg_enable_out_n = r_reg.en_out_n;
  assign load_done = r_reg.done;
  assign init_reset = r_reg.init_rst;
  assign user_mode = r_reg.user;
  assign user_io_oe = r_reg.io_oe;
  assign cfg_error = r_reg.err;
  assign cfg_checksum = r_reg.checksum;
  assign pll_settings = r_reg.pll_set;
endmodule // cms_top

// ===== verif/cms_cfg_source.sv
// ----
// External data source, all schemes
// ----
module cms_cfg_source (
  input wire logic clk, // Clock
  input wire logic cfg_ready, // Device takes data
  input wire cms_pkg::cms_scheme_t scheme, // Scheme driven
  input wire logic run, // Supply data
  input wire logic noise, // Strobe other schemes too
  output cms_pkg::cms_src_t src, // To device
  output logic [7:0] n_sent // Bytes taken
);
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;
  logic v = 1'b0;
  logic t = 1'b0;
  logic [2:0] bi = 3'h0;
  logic [7:0] b;
  logic ser;
  logic last;
  initial n_sent = 8'h00;
  assign ser = scheme == SCH_PASSIVE_SERIAL || scheme == SCH_SCAN;
  // Idle data toggles so a stale value never looks valid
  assign b = (8'hA5 + n_sent * 8'h13) ^ {8{~v & t}};
  assign last = v && cfg_ready && (!ser || bi == 3'h7);
  // Unit held until an edge sees ready; LSB first
  always @(posedge clk) begin
    t <= ~t;
    if (!run) begin
      n_sent <= 8'h00;
      bi <= 3'h0;
      v <= 1'b0;
    end else begin
      if (v && cfg_ready) begin
        bi <= ser ? bi + 3'h1 : 3'h0;
      end
      if (last) begin
        n_sent <= n_sent + 8'h01;
      end
      v <= (n_sent + {7'h00, last}) < 8'(CFG_BYTES);
    end
  end
  function automatic logic on(cms_scheme_t s);
    return v && (scheme == s || noise);
  endfunction
  always_comb begin
    src.mem_valid = on(SCH_MEMORY);
    src.mem_byte = scheme == SCH_MEMORY ? b : ~b;
    src.ps_valid = on(SCH_PASSIVE_SERIAL);
    src.ps_bit = b[bi] ^ (scheme != SCH_PASSIVE_SERIAL);
    src.ppa_valid = on(SCH_PASSIVE_PARALLEL_ASYNC);
    src.ppa_byte = scheme == SCH_PASSIVE_PARALLEL_ASYNC ? b : ~b;
    src.fpp_valid = on(SCH_FAST_PASSIVE_PARALLEL);
    src.fpp_byte = scheme == SCH_FAST_PASSIVE_PARALLEL ? b : ~b;
    src.scan_valid = on(SCH_SCAN);
    src.scan_bit = b[bi] ^ (scheme != SCH_SCAN);
  end
endmodule // cms_cfg_source

// ===== verif/cms_checker.sv
// ----
// Mode sequencing checks
// ----
module cms_checker (
  input wire logic clk, // Clock
  input wire logic rstn, // Reset
  input wire logic reconfig_request_n, // Request
  input wire logic scan_reconfig_pulse_instr, // Scan pulse
  input wire cms_pkg::cms_pll_in_t pll_in, // PLL chain
  input wire logic cfg_ready, // Ready
  input wire logic cfg_enable_out_n, // Enable out
  input wire logic load_done, // Loaded
  input wire logic init_reset, // Init
  input wire logic user_mode, // User mode
  input wire logic user_io_oe, // I/O drive
  input wire logic cfg_error, // Overrun
  input wire cms_pkg::cms_pll_set_t pll_settings // PLL set
);
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  property p_oe;
    user_io_oe |-> user_mode;
  endproperty
  a_oe: assert property (p_oe)
    else $error("I/O driven outside user mode");
  property p_req;
    !reconfig_request_n |=> !user_mode && !user_io_oe && !load_done;
  endproperty
  a_req: assert property (p_req)
    else $error("request did not leave user mode");
  property p_scan;
    scan_reconfig_pulse_instr |=> !user_mode && cfg_enable_out_n;
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan pulse ignored");
  property p_eo;
    !cfg_enable_out_n |-> load_done;
  endproperty
  a_eo: assert property (p_eo)
    else $error("enable out before load done");
  // Aborted init is legal, so a request cancels the check
  property p_init;
    disable iff (!rstn || !reconfig_request_n || scan_reconfig_pulse_instr)
    $rose(init_reset) |-> init_reset[*8] ##1 (!init_reset && user_mode);
  endproperty
  a_init: assert property (p_init)
    else $error("init length wrong");
  property p_ready;
    cfg_ready |-> !load_done && !user_mode;
  endproperty
  a_ready: assert property (p_ready)
    else $error("data taken outside load");
  property p_pll;
    !(pll_in.update && user_mode) |=> $stable(pll_settings);
  endproperty
  a_pll: assert property (p_pll)
    else $error("PLL settings moved");
  property p_keep;
    user_mode && reconfig_request_n && !scan_reconfig_pulse_instr
      |=> user_mode;
  endproperty
  a_keep: assert property (p_keep)
    else $error("user mode dropped");
  property p_err;
    cfg_error |-> !user_mode && !load_done;
  endproperty
  a_err: assert property (p_err)
    else $error("error with device running");
endmodule // cms_checker

// ===== verif/test_config_mode_sequencer.sv
// ----
// Sequencer bench
// ----
module test_config_mode_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import cms_pkg::*;
  localparam int unsigned LIM = 300;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reconfig_request_n = 1'b1;
  logic scan_reconfig_pulse_instr = 1'b0;
  logic cfg_enable_in_n = 1'b1;
  cms_scheme_t scheme_sel = SCH_FAST_PASSIVE_PARALLEL;
  cms_pll_in_t pll_in = '0;
  cms_src_t src;
  logic run = 1'b0;
  logic noise = 1'b0;
  logic cfg_ready, cfg_enable_out_n, load_done, init_reset;
  logic user_mode, user_io_oe, cfg_error;
  logic [7:0] cfg_checksum, n_sent;
  cms_pll_set_t pll_settings;
  int fail_count = 0;
  int n_compared = 0;
  always #12.5 clk = ~clk;
  cms_top #(.LOAD_LIMIT(LIM)) i_cms_top (.clk, .rstn,
    .reconfig_request_n, .scan_reconfig_pulse_instr, .cfg_enable_in_n,
    .scheme_sel, .src, .pll_in, .cfg_ready, .cfg_enable_out_n, .load_done,
    .init_reset, .user_mode, .user_io_oe, .cfg_error, .cfg_checksum,
    .pll_settings);
  cms_cfg_source i_cms_cfg_source (.clk, .cfg_ready, .scheme(scheme_sel),
    .run, .noise, .src, .n_sent);
  task automatic check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [7:0] xsum();
    logic [7:0] x = 8'h00;
    for (int k = 0; k < CFG_BYTES; k++) x ^= 8'hA5 + 8'(k) * 8'h13;
    return x;
  endfunction
  task automatic finish_load();
    int i;
    for (i = 0; i < 2000 && user_mode !== 1'b1; i++) @(negedge clk);
    if (i == 2000) begin
      fail_count++;
      complete_run();
    end
    check(n_sent, 16);
    check(cfg_checksum, xsum());
    check(cfg_enable_out_n, 0);
    check(user_io_oe, 1);
    check(init_reset, 0);
    check(load_done, 1);
    @(posedge clk);
    run <= 1'b0;
    noise <= 1'b0;
  endtask
  task automatic reconfig();
    @(posedge clk);
    reconfig_request_n <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    check({user_mode, user_io_oe, load_done}, 0);
    check(cfg_enable_out_n, 1);
    @(posedge clk);
    reconfig_request_n <= 1'b1;
  endtask
  task automatic t_powerup();
    logic full = 1'b0;
    @(posedge clk);
    run <= 1'b1;
    repeat (20) @(negedge clk);
    check(cfg_ready, 0);
    check(cfg_enable_out_n, 1);
    check({user_mode, user_io_oe}, 0);
    @(posedge clk);
    cfg_enable_in_n <= 1'b0;
    repeat (14) begin
      @(negedge clk);
      full |= cfg_ready === 1'b0 && n_sent > 8'h00;
    end
    check(full, 1);
    finish_load();
  endtask
  task automatic t_schemes();
    for (int s = 0; s < 5; s++) begin
      @(posedge clk);
      scheme_sel <= cms_scheme_t'(s);
      noise <= 1'b1;
      run <= 1'b1;
      reconfig();
      finish_load();
    end
  endtask
  task automatic t_scan();
    @(posedge clk);
    scan_reconfig_pulse_instr <= 1'b1;
    @(posedge clk);
    scan_reconfig_pulse_instr <= 1'b0;
    run <= 1'b1;
    @(negedge clk);
    check({user_mode, cfg_enable_out_n}, 1);
    finish_load();
  endtask
  task automatic t_pll();
    logic [17:0] v = 18'h2D5A3;
    for (int i = 17; i >= 0; i--) begin
      @(posedge clk);
      pll_in <= {1'b1, i[0], v[i] ^ i[0], v[i] ^ ~i[0], 1'b0};
    end
    @(posedge clk);
    pll_in <= 5'h01;
    @(posedge clk);
    pll_in <= 5'h00;
    @(negedge clk);
    check(pll_settings, v);
    check(user_mode, 1);
  endtask
  task automatic t_timeout();
    reconfig();
    repeat (LIM + 20) @(negedge clk);
    check(cfg_error, 1);
    check(user_io_oe, 0);
    reconfig();
    @(negedge clk);
    check(cfg_error, 0);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_powerup();
    t_schemes();
    t_scan();
    t_pll();
    t_timeout();
    complete_run();
  end
endmodule // test_config_mode_sequencer
bind cms_top cms_checker i_cms_checker (.clk, .rstn, .reconfig_request_n,
  .scan_reconfig_pulse_instr, .pll_in, .cfg_ready, .cfg_enable_out_n,
  .load_done, .init_reset, .user_mode, .user_io_oe, .cfg_error,
  .pll_settings);
